// ===== src/erbs_map.vh
/*
  Constants for the emulation reset and bus select block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ERBS_MAP_VH
`define ERBS_MAP_VH
`define ERBS_IO_ADDR_W     11
`define ERBS_IO_ADDR_MAX   11'h7ff
`define ERBS_DREG_NUM      16
`define ERBS_DREG_IDX_W    4
`define ERBS_DATA_W        16
`define ERBS_BOOT_W        3
`define ERBS_BOOT_RST      3'h0
`define ERBS_BOOT_MODE_A   0
`define ERBS_BOOT_MODE_B   1
`define ERBS_BOOT_MODE_C   2
`define ERBS_ST_RUN        3'h1
`define ERBS_ST_IOWAIT     3'h2
`define ERBS_ST_GRANT      3'h4
`endif

// ===== src/erbs_regfile.v
/*
  Data register file of 16 words with one write and two read ports.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`include "erbs_map.vh"
module erbs_regfile #(
  parameter DATA_W = `ERBS_DATA_W,
  parameter NUM    = `ERBS_DREG_NUM,
  parameter IDX_W  = `ERBS_DREG_IDX_W
)(
  input  wire              clk_sys,
  input  wire              rst_b,
  input  wire              wr_en,
  input  wire [IDX_W-1:0]  wr_idx,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [IDX_W-1:0]  rd_idx,
  output wire [DATA_W-1:0] rd_data,
  input  wire [IDX_W-1:0]  peek_idx,
  output wire [DATA_W-1:0] peek_data
);
  wire [DATA_W*NUM-1:0] flat;
  genvar i;
  generate
    for (i = 0; i < NUM; i = i + 1)
    begin : g_reg
      localparam [IDX_W-1:0] SLOT = i;
      reg [DATA_W-1:0] dreg_ff;
      always @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
          dreg_ff <= {DATA_W{1'b0}};
        else if (wr_en && wr_idx == SLOT)
          dreg_ff <= wr_data;
      end
      assign flat[i*DATA_W +: DATA_W] = dreg_ff;
    end
  endgenerate
  assign rd_data   = flat[rd_idx*DATA_W +: DATA_W];
  assign peek_data = flat[peek_idx*DATA_W +: DATA_W];
endmodule

// ===== src/erbs_top.v
/*
  Emulation reset and bus select logic with the I/O space move unit.
  Assumes all pins synchronous to clk_sys; rst_b is the power-on reset.
  Pin resets are sampled and act as synchronous chip resets here.
*/
// Behaviour
// - I/O moves take address 0 to 2047 and any of 16 data registers
// - I/O write sends register to location; read loads location into it
// - Boot pins sampled on rising edge of target reset, then held
// - Emulator reset is full chip reset and relatches boot pins, except during single-step or halt in emulator space
// - Emulator enable selects emulator reset and grant pins and adds emulator request to target request
// - Emulator enable three-states target bus grant output
// - Single-step ignores target reset and target bus request
// - Halt in emulator space ignores target reset and bus request
// - Emulation pins have no effect outside emulation
// - Idle bus and request: next cycle float bus, grant, halt
`timescale 1ns/100ps
`include "erbs_map.vh"
module erbs_top #(
  parameter ADDR_W = `ERBS_IO_ADDR_W,
  parameter DATA_W = `ERBS_DATA_W,
  parameter IDX_W  = `ERBS_DREG_IDX_W,
  parameter BOOT_W = `ERBS_BOOT_W
)(
  input  wire              clk_sys,
  input  wire              rst_b,
  input  wire              target_reset_n,
  input  wire              target_bus_request_n,
  input  wire              emulator_enable,
  input  wire              emu_reset_n,
  input  wire              emu_bus_request_n,
  input  wire              emu_single_step,
  input  wire              emu_space_halt,
  input  wire [BOOT_W-1:0] boot_pins,
  input  wire              io_req,
  input  wire              io_write,
  input  wire [ADDR_W-1:0] io_addr,
  input  wire [IDX_W-1:0]  io_dreg,
  input  wire [DATA_W-1:0] io_rdata,
  input  wire              io_ack,
  input  wire              dreg_wr,
  input  wire [IDX_W-1:0]  dreg_wr_idx,
  input  wire [DATA_W-1:0] dreg_wr_data,
  input  wire [IDX_W-1:0]  dreg_peek_idx,
  output reg  [DATA_W-1:0] dreg_peek_ff,
  output reg               io_strobe_ff,
  output reg               io_we_ff,
  output reg  [ADDR_W-1:0] io_addr_out_ff,
  output reg  [DATA_W-1:0] io_wdata_ff,
  output reg               io_busy_ff,
  output reg               bus_float_ff,
  output reg               core_halt_ff,
  output reg               target_bus_grant_n_ff,
  output reg               target_bus_grant_oe_ff,
  output reg               emu_bus_grant_n_ff,
  output reg  [BOOT_W-1:0] boot_cfg_ff,
  output reg               chip_reset_ff
);
  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg               trst_d_ff;
  reg               erst_d_ff;
  reg  [IDX_W-1:0]  dreg_idx_ff;
  wire [DATA_W-1:0] rf_rd_data;
  wire [DATA_W-1:0] rf_peek_data;
  wire              ignore_target;
  wire              eff_reset_n;
  wire              eff_breq;
  wire              chip_reset;
  wire              load_en;
  wire              grant_next;
  wire              io_start;

  // Emulator pins only matter while enabled
  assign ignore_target = emulator_enable &
                         (emu_single_step | emu_space_halt);
  assign eff_reset_n = emulator_enable ? emu_reset_n
                       : target_reset_n;
  assign eff_breq = emulator_enable
                    ? (~emu_bus_request_n |
                       (~ignore_target & ~target_bus_request_n))
                    : ~target_bus_request_n;
  // Same reset path for either source
  assign chip_reset = (emulator_enable ? ~emu_reset_n
                       : ~target_reset_n) & ~ignore_target;
  assign load_en = (state_ff == `ERBS_ST_IOWAIT) & io_ack & ~io_we_ff;
  assign grant_next = (nxt_state == `ERBS_ST_GRANT);
  // Request wins over a new access in the same cycle
  assign io_start = (state_ff == `ERBS_ST_RUN) & ~eff_breq & io_req;

  erbs_regfile #(
    .DATA_W (DATA_W),
    .NUM    (`ERBS_DREG_NUM),
    .IDX_W  (IDX_W)
  ) u_regfile (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .wr_en     (load_en | dreg_wr),
    .wr_idx    (load_en ? dreg_idx_ff : dreg_wr_idx),
    .wr_data   (load_en ? io_rdata : dreg_wr_data),
    .rd_idx    (io_dreg),
    .rd_data   (rf_rd_data),
    .peek_idx  (dreg_peek_idx),
    .peek_data (rf_peek_data)
  );

  // Boot strap capture on release edge of the selected reset
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trst_d_ff   <= 1'b1;
      erst_d_ff   <= 1'b1;
      boot_cfg_ff <= `ERBS_BOOT_RST;
    end
    else
    begin
      trst_d_ff <= target_reset_n;
      erst_d_ff <= emu_reset_n;
      if (emulator_enable && !ignore_target && emu_reset_n && !erst_d_ff)
        boot_cfg_ff <= boot_pins;
      else if (!emulator_enable && target_reset_n && !trst_d_ff)
        boot_cfg_ff <= boot_pins;
    end
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `ERBS_ST_RUN:
      begin
        if (eff_breq)
          nxt_state = `ERBS_ST_GRANT;
        else if (io_req)
          nxt_state = `ERBS_ST_IOWAIT;
      end
      `ERBS_ST_IOWAIT:
      begin
        // Grant waits until the access completes
        if (io_ack)
          nxt_state = eff_breq ? `ERBS_ST_GRANT : `ERBS_ST_RUN;
      end
      `ERBS_ST_GRANT:
      begin
        if (!eff_breq)
          nxt_state = `ERBS_ST_RUN;
      end
      default:
        nxt_state = `ERBS_ST_RUN;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff      <= `ERBS_ST_RUN;
      chip_reset_ff <= 1'b0;
      dreg_peek_ff  <= {DATA_W{1'b0}};
    end
    else
    begin
      state_ff      <= nxt_state;
      chip_reset_ff <= chip_reset;
      dreg_peek_ff  <= rf_peek_data;
    end
  end

  // I/O move registers
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_strobe_ff   <= 1'b0;
      io_we_ff       <= 1'b0;
      io_addr_out_ff <= {ADDR_W{1'b0}};
      io_wdata_ff    <= {DATA_W{1'b0}};
      io_busy_ff     <= 1'b0;
      dreg_idx_ff    <= {IDX_W{1'b0}};
    end
    else
    begin
      if (io_start)
      begin
        io_strobe_ff   <= 1'b1;
        io_we_ff       <= io_write;
        io_addr_out_ff <= io_addr;
        io_wdata_ff    <= rf_rd_data;
        dreg_idx_ff    <= io_dreg;
        io_busy_ff     <= 1'b1;
      end
      else if (state_ff == `ERBS_ST_IOWAIT && io_ack)
      begin
        io_strobe_ff <= 1'b0;
        io_busy_ff   <= 1'b0;
      end
    end
  end

  // Grant pins; bus request keeps working during pin resets
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_float_ff           <= 1'b0;
      core_halt_ff           <= 1'b0;
      target_bus_grant_n_ff  <= 1'b1;
      target_bus_grant_oe_ff <= 1'b1;
      emu_bus_grant_n_ff     <= 1'b1;
    end
    else
    begin
      bus_float_ff           <= grant_next;
      core_halt_ff           <= grant_next;
      target_bus_grant_n_ff  <= ~(grant_next & ~emulator_enable);
      target_bus_grant_oe_ff <= ~emulator_enable;
      emu_bus_grant_n_ff     <= ~(grant_next & emulator_enable);
    end
  end
endmodule

// ===== tb/erbs_io_model.sv
/*
  I/O space memory behind the move unit.
  Assumes the strobe is held until the answer pulse.
*/
`timescale 1ns/100ps
module erbs_io_model (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        slow,
  input wire        io_strobe_ff,
  input wire        io_we_ff,
  input wire [10:0] io_addr_out_ff,
  input wire [15:0] io_wdata_ff,
  output reg [15:0] io_rdata,
  output reg        io_ack
);
  reg  [15:0] mem [0:2047];
  reg  [1:0]  cnt_ff;
  wire        hit = io_strobe_ff && !io_ack && cnt_ff == {2{slow}};
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      cnt_ff <= 2'h0;
      io_ack <= 1'b0;
      io_rdata <= 16'h0;
    end
    else
    begin
      cnt_ff <= (io_strobe_ff && !hit) ? cnt_ff + 2'h1 : 2'h0;
      io_ack <= hit;
      // Data toggles off the answer so a stale read cannot pass
      io_rdata <= hit ? mem[io_addr_out_ff] : ~io_rdata;
      if (hit && io_we_ff)
        mem[io_addr_out_ff] <= io_wdata_ff;
    end
endmodule

// ===== tb/erbs_properties.sv
/*
  Port checker for erbs_top.
  Assumes binding to erbs_top; sees its ports only.
*/
`timescale 1ns/100ps
module erbs_properties (
  input wire       clk_sys,
  input wire       rst_b,
  input wire       target_reset_n,
  input wire       target_bus_request_n,
  input wire       emulator_enable,
  input wire       emu_reset_n,
  input wire       emu_bus_request_n,
  input wire       emu_single_step,
  input wire       emu_space_halt,
  input wire       io_ack,
  input wire       io_busy_ff,
  input wire       bus_float_ff,
  input wire       core_halt_ff,
  input wire       target_bus_grant_n_ff,
  input wire       target_bus_grant_oe_ff,
  input wire       emu_bus_grant_n_ff,
  input wire [2:0] boot_cfg_ff,
  input wire       chip_reset_ff
);
  wire ee  = emulator_enable;
  wire dbg = ee && (emu_single_step || emu_space_halt);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  boot_hold_a:
    assert property (target_reset_n && $past(target_reset_n) && !ee
      && $past(target_reset_n, 2) && !$past(ee) |=> $stable(boot_cfg_ff))
      else $error("boot config moved while reset high");
  emu_reset_a:
    assert property (ee && !emu_reset_n && !dbg |=> chip_reset_ff)
      else $error("emulator reset gave no chip reset");
  tgt_reset_a:
    assert property (!ee && !target_reset_n |=> chip_reset_ff)
      else $error("target reset gave no chip reset");
  emu_grant_a:
    assert property (ee && !emu_bus_request_n && !io_busy_ff
      |=> !emu_bus_grant_n_ff && core_halt_ff && bus_float_ff)
      else $error("emulator request not granted");
  grant_oe_a:
    assert property (ee && $past(ee) |-> !target_bus_grant_oe_ff)
      else $error("target grant driven under emulation");
  step_ign_a:
    assert property (ee && emu_single_step && emu_reset_n
      && emu_bus_request_n |=> !chip_reset_ff && emu_bus_grant_n_ff)
      else $error("target pins obeyed while stepping");
  halt_ign_a:
    assert property (ee && emu_space_halt && emu_bus_request_n
      |=> !core_halt_ff && emu_bus_grant_n_ff)
      else $error("target request obeyed while halted");
  no_emu_eff_a:
    assert property (!ee && target_reset_n && target_bus_request_n
      |=> !chip_reset_ff && emu_bus_grant_n_ff && target_bus_grant_n_ff)
      else $error("emulation pins acted outside emulation");
  tgt_grant_a:
    assert property (!ee && !target_bus_request_n && !io_busy_ff
      |=> bus_float_ff && core_halt_ff && !target_bus_grant_n_ff)
      else $error("target request not granted next cycle");
  io_end_a:
    assert property (io_busy_ff && io_ack |=> !io_busy_ff)
      else $error("I/O access outlived its answer");
  cover property (!emu_bus_grant_n_ff);
  cover property (!target_bus_grant_n_ff);
  cover property ($fell(io_busy_ff));
endmodule
bind erbs_top erbs_properties i_chk (.*);

// ===== tb/tb.sv
/*
  Self-checking bench for erbs_top with the I/O memory model.
  Assumes pins are driven on clk_sys rising edges.
*/
`timescale 1ns/100ps
module tb;
  reg clk_sys = 0, rst_b = 0, target_reset_n = 1, emu_reset_n = 1;
  reg target_bus_request_n = 1, emu_bus_request_n = 1, slow = 0;
  reg emulator_enable = 0, emu_single_step = 0, emu_space_halt = 0;
  reg io_req = 0, io_write = 0, dreg_wr = 0;
  reg [2:0] boot_pins = 3'h6;
  reg [10:0] io_addr = 11'h0;
  reg [3:0] io_dreg = 4'h0, dreg_wr_idx = 4'h0, dreg_peek_idx = 4'h0;
  reg [15:0] dreg_wr_data = 16'h0;
  reg [30:0] rows [0:3];
  wire [15:0] io_rdata, dreg_peek_ff, io_wdata_ff;
  wire [10:0] io_addr_out_ff;
  wire [2:0] boot_cfg_ff;
  wire io_ack, io_strobe_ff, io_we_ff, io_busy_ff, bus_float_ff;
  wire core_halt_ff, target_bus_grant_n_ff, target_bus_grant_oe_ff;
  wire emu_bus_grant_n_ff, chip_reset_ff;
  integer err_count = 0, num_checks = 0, i, k;
  `define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
  always #4 clk_sys = ~clk_sys;
  erbs_top i_dut (.*);
  erbs_io_model i_mem (.*);
  task step(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task io(input w, input [10:0] a, input [3:0] r);
    begin
      io_req <= 1'b1;
      io_write <= w;
      io_addr <= a;
      io_dreg <= r;
      for (k = 0; k < 20 && io_busy_ff !== 1'b1; k++) step(1);
      io_req <= 1'b0;
      for (k = 0; k < 20 && io_busy_ff !== 1'b0; k++) step(1);
      step(2);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #20000;
    err_count++;
    finish_test;
  end
  initial
  begin
    rows[0] = {11'h000, 4'h0, 16'ha5c3};
    rows[1] = {11'h7ff, 4'hf, 16'h5a3c};
    rows[2] = {11'h400, 4'h7, 16'hffff};
    rows[3] = {11'h001, 4'h8, 16'h0001};
    step(8);
    rst_b <= 1'b1;
    #1 `CHK("oe rst", 1'b1, target_bus_grant_oe_ff)
    for (i = 0; i < 4; i++)
    begin
      step(1);
      slow <= i[0];
      dreg_wr <= 1'b1;
      dreg_wr_idx <= rows[i][19:16];
      dreg_wr_data <= rows[i][15:0];
      dreg_peek_idx <= ~rows[i][19:16];
      step(1);
      dreg_wr <= 1'b0;
      io(1'b1, rows[i][30:20], rows[i][19:16]);
      io(1'b0, rows[i][30:20], ~rows[i][19:16]);
      #1 `CHK("peek", rows[i][15:0], dreg_peek_ff)
    end
    step(1);
    target_reset_n <= 1'b0;
    step(2);
    #1 `CHK("chip rst", 1'b1, chip_reset_ff)
    step(1);
    target_reset_n <= 1'b1;
    step(4);
    boot_pins <= 3'h1;
    emu_reset_n <= 1'b0;
    emu_bus_request_n <= 1'b0;
    step(3);
    #1 `CHK("boot tgt", 3'h6, boot_cfg_ff)
    `CHK("no emu rst", 1'b0, chip_reset_ff)
    `CHK("no emu grant", 1'b1, emu_bus_grant_n_ff)
    step(1);
    emulator_enable <= 1'b1;
    step(3);
    #1 `CHK("emu grant", 1'b0, emu_bus_grant_n_ff)
    `CHK("oe emu", 1'b0, target_bus_grant_oe_ff)
    `CHK("emu rst", 1'b1, chip_reset_ff)
    step(1);
    emu_reset_n <= 1'b1;
    emu_bus_request_n <= 1'b1;
    step(4);
    #1 `CHK("boot emu", 3'h1, boot_cfg_ff)
    step(1);
    // Single-step with target reset and target bus request both asserted
    emu_single_step <= 1'b1;
    target_reset_n <= 1'b0;
    target_bus_request_n <= 1'b0;
    step(3);
    #1 `CHK("step rst", 1'b0, chip_reset_ff)
    `CHK("step br", 1'b1, emu_bus_grant_n_ff)
    step(1);
    emu_single_step <= 1'b0;
    emu_space_halt <= 1'b1;
    step(3);
    #1 `CHK("halt rst", 1'b0, chip_reset_ff)
    `CHK("halt br", 1'b0, core_halt_ff)
    step(1);
    emu_space_halt <= 1'b0;
    emulator_enable <= 1'b0;
    target_reset_n <= 1'b1;
    step(2);
    #1 `CHK("tgt grant", 1'b0, target_bus_grant_n_ff)
    `CHK("float", 1'b1, bus_float_ff)
    step(1);
    target_bus_request_n <= 1'b1;
    step(3);
    finish_test;
  end
endmodule
